// ### verilog/fcwl_loader.sv
// volatile configuration registers refilled from flash on every reset
`timescale 1ns/100ps
`default_nettype none
module fcwl_loader (
  input wire logic clk,
  input wire logic resetn,
  output logic flash_rd,
  output logic [23:0] flash_addr,
  input wire logic flash_rvalid,
  input wire logic [23:0] flash_rdata,
  input wire logic tbl_rd,
  input wire logic tbl_wr,
  input wire logic [23:0] tbl_addr,
  input wire logic [23:0] tbl_wdata,
  output logic tbl_ack,
  output logic [23:0] tbl_rdata,
  output logic sys_reset_hold,
  output logic [23:0] cfg_word_two,
  output logic boundary_port_on,
  output logic code_protect_on,
  output logic flash_write_block,
  output logic debug_reset_mode,
  output logic [1:0] emulator_pin_pair_sel,
  output logic [2:0] emulator_pair_onehot,
  output logic watchdog_on,
  output logic window_watchdog_off,
  output logic window_watchdog_active,
  output logic [7:0] watchdog_prescale_div,
  output logic [3:0] watchdog_postscale_sel,
  output logic [15:0] watchdog_postscale_div
);
  fcwl_load_if lif ();

  fcwl_fetch u_fetch (
    .clk(clk),
    .resetn(resetn),
    .flash_rd(flash_rd),
    .flash_addr(flash_addr),
    .flash_rvalid(flash_rvalid),
    .flash_rdata(flash_rdata),
    .lif(lif)
  );

  logic [15:0] cfg, next_cfg;
  logic ack, next_ack;
  logic [23:0] rdata, next_rdata;
  logic [23:0] word_two, next_word_two;
  logic [23:0] loc_off;
  logic [4:0] loc_hit;
  logic in_space;
  logic [15:0] sel_mask;

  assign in_space = (tbl_addr >= fcwl_pkg::CFG_SPACE_BASE);
  assign loc_off = tbl_addr - fcwl_pkg::CFG_LOC_BASE;

  // five locations, one hit decoder each
  genvar gi;
  generate
    for (gi = 0; gi < fcwl_pkg::NUM_LOC; gi++) begin : g_loc
      assign loc_hit[gi] = (loc_off == 24'(gi) * fcwl_pkg::CFG_LOC_STEP);
    end
  endgenerate

  always_comb begin
    sel_mask = 16'h0000;
    for (int i = 0; i < fcwl_pkg::NUM_LOC; i++) begin
      if (loc_hit[i]) begin
        sel_mask = sel_mask | fcwl_pkg::LOC_MASK[i];
      end
    end
  end

  always_comb begin
    next_cfg = cfg;
    next_word_two = word_two;
    next_ack = 1'b0;
    next_rdata = rdata;
    // load wins; the hold keeps table accesses out of that cycle
    if (lif.load_strobe) begin
      next_cfg = lif.word_one[15:0];
      next_word_two = lif.word_two;
    end else if (!lif.loading && in_space && (tbl_rd || tbl_wr)) begin
      next_ack = 1'b1;
      if (tbl_wr) begin
        // upper bits and unmapped bits ignored
        next_cfg = (cfg & ~sel_mask) | (tbl_wdata[15:0] & sel_mask);
      end else begin
        // stored bits read as stored, unmapped read as ones
        next_rdata = {fcwl_pkg::UPPER_ONES, (cfg & sel_mask) | ~sel_mask};
      end
    end
  end

  // reset leaves unprogrammed ones until refilled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg <= fcwl_pkg::CFG_RESET;
      word_two <= 24'hffffff;
      ack <= 1'b0;
      rdata <= 24'hffffff;
    end else begin
      cfg <= next_cfg;
      word_two <= next_word_two;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign tbl_ack = ack;
  assign tbl_rdata = rdata;
  assign cfg_word_two = word_two;

  // consumers stay in reset while loading
  assign sys_reset_hold = !resetn || lif.loading;

  assign boundary_port_on = cfg[fcwl_pkg::BIT_BOUNDARY];
  assign code_protect_on = !cfg[fcwl_pkg::BIT_CODE_PROT_N];
  assign flash_write_block = !cfg[fcwl_pkg::BIT_WRITE_PROT_N];
  assign debug_reset_mode = !cfg[fcwl_pkg::BIT_OPERATIONAL];
  // pin pair decode; reserved code selects none
  assign emulator_pin_pair_sel = cfg[fcwl_pkg::BIT_PAIR_HI:fcwl_pkg::BIT_PAIR_LO];
  assign emulator_pair_onehot = {emulator_pin_pair_sel == fcwl_pkg::PAIR_THREE,
                                 emulator_pin_pair_sel == fcwl_pkg::PAIR_TWO,
                                 emulator_pin_pair_sel == fcwl_pkg::PAIR_ONE};
  assign watchdog_on = cfg[fcwl_pkg::BIT_WDOG_ON];
  assign window_watchdog_off = cfg[fcwl_pkg::BIT_WINDOW_OFF];
  // window mode only counts with the watchdog on
  assign window_watchdog_active = !window_watchdog_off && watchdog_on;
  assign watchdog_prescale_div = cfg[fcwl_pkg::BIT_PRESCALE] ? fcwl_pkg::PRESCALE_LONG
                                                              : fcwl_pkg::PRESCALE_SHORT;
  assign watchdog_postscale_sel = cfg[fcwl_pkg::BIT_POST_HI:0];
  assign watchdog_postscale_div = 16'h0001 << watchdog_postscale_sel;

  sequence load_done_s;
    lif.load_strobe ##1 1'b1;
  endsequence

  // accepted table access, one per cycle
  sequence tbl_take_s;
    (tbl_rd || tbl_wr) && in_space && !sys_reset_hold;
  endsequence

  // hold drops only with the new image in place
  hold_release_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(sys_reset_hold) |-> cfg == lif.word_one[15:0])
    else $error("reset released before load");
  held_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
    (tbl_rd || tbl_wr) && sys_reset_hold |=> !tbl_ack)
    else $error("answered while held");
  reload_hold_a: assert property (@(posedge clk)
    !resetn ##1 resetn |-> sys_reset_hold)
    else $error("no reload after reset");
  reset_ones_a: assert property (@(posedge clk)
    !resetn |=> cfg == fcwl_pkg::CFG_RESET)
    else $error("reset image not ones");
  // loaded image matches the flash word
  unpack_copy_a: assert property (@(posedge clk) disable iff (!resetn)
    lif.load_strobe |=> cfg == $past(lif.word_one[15:0]))
    else $error("word not unpacked");
  upper_ones_a: assert property (@(posedge clk) disable iff (!resetn)
    tbl_ack |-> tbl_rdata[23:16] == 8'hff)
    else $error("upper byte not ones");
  // write touches only the hit mask
  write_mask_a: assert property (@(posedge clk) disable iff (!resetn)
    tbl_wr && in_space && !sys_reset_hold
    |=> (cfg & ~$past(sel_mask)) == ($past(cfg) & ~$past(sel_mask)))
    else $error("write outside mask");
  space_only_a: assert property (@(posedge clk) disable iff (!resetn)
    (tbl_rd || tbl_wr) && tbl_addr < 24'h800000 |=> !tbl_ack)
    else $error("answered outside config space");
  ack_answer_a: assert property (@(posedge clk) disable iff (!resetn)
    tbl_take_s |=> tbl_ack)
    else $error("access not answered");
  unmapped_ones_a: assert property (@(posedge clk) disable iff (!resetn)
    tbl_rd && !tbl_wr && in_space && !sys_reset_hold && sel_mask == 16'h0000
    |=> tbl_rdata == 24'hffffff)
    else $error("unmapped read not ones");
  boundary_load_a: assert property (@(posedge clk) disable iff (!resetn)
    load_done_s |-> boundary_port_on == $past(lif.word_one[14]))
    else $error("port enable wrong");
  code_prot_a: assert property (@(posedge clk) disable iff (!resetn)
    load_done_s |-> code_protect_on == !$past(lif.word_one[13]))
    else $error("code protect wrong");
  write_prot_a: assert property (@(posedge clk) disable iff (!resetn)
    load_done_s |-> flash_write_block == !$past(lif.word_one[12]))
    else $error("write protect wrong");
  debug_load_a: assert property (@(posedge clk) disable iff (!resetn)
    load_done_s |-> debug_reset_mode == !$past(lif.word_one[11]))
    else $error("debug mode wrong");
  pair_load_a: assert property (@(posedge clk) disable iff (!resetn)
    load_done_s |-> emulator_pin_pair_sel == $past(lif.word_one[9:8]))
    else $error("pin pair wrong");
  wdog_load_a: assert property (@(posedge clk) disable iff (!resetn)
    load_done_s |-> watchdog_on == $past(lif.word_one[7]))
    else $error("watchdog enable wrong");
  window_needs_a: assert property (@(posedge clk) disable iff (!resetn)
    load_done_s |-> window_watchdog_active ==
    (!$past(lif.word_one[6]) && $past(lif.word_one[7])))
    else $error("window without watchdog");
  prescale_ratio_a: assert property (@(posedge clk) disable iff (!resetn)
    load_done_s |-> watchdog_prescale_div == ($past(lif.word_one[4]) ? 8'h80 : 8'h20))
    else $error("prescale wrong");
  postscale_load_a: assert property (@(posedge clk) disable iff (!resetn)
    load_done_s |-> watchdog_postscale_div == (16'h0001 << $past(lif.word_one[3:0])))
    else $error("postscale code wrong");
  postscale_top_a: assert property (@(posedge clk) disable iff (!resetn)
    watchdog_postscale_sel == 4'hf |-> watchdog_postscale_div == 16'h8000)
    else $error("postscale wrong");
  // reserved pair code selects no pins
  pair_reserved_a: assert property (@(posedge clk) disable iff (!resetn)
    emulator_pin_pair_sel == 2'h0 |-> emulator_pair_onehot == 3'h0)
    else $error("reserved pair used");
endmodule : fcwl_loader
`default_nettype wire

// ### verilog/fcwl_pkg.sv
// constants for the flash configuration word loader
package fcwl_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned CFG_W = 16;
  localparam int unsigned NUM_LOC = 5;
  // flash words at the top of program memory
  localparam logic [23:0] CW_ONE_ADDR = 24'h00abfe;
  localparam logic [23:0] CW_TWO_ADDR = 24'h00abfc;
  // configuration space and the five unpacked locations
  localparam logic [23:0] CFG_SPACE_BASE = 24'h800000;
  localparam logic [23:0] CFG_LOC_BASE = 24'hf80000;
  localparam logic [23:0] CFG_LOC_STEP = 24'h000002;
  localparam logic [7:0] UPPER_ONES = 8'hff;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'hffff;
  localparam logic [CFG_W-1:0] LOC_MASK [NUM_LOC] = '{
    16'h7000, 16'h0800, 16'h0300, 16'h00d0, 16'h000f};
  // field positions in the first word
  localparam int unsigned BIT_BOUNDARY = 14;
  localparam int unsigned BIT_CODE_PROT_N = 13;
  localparam int unsigned BIT_WRITE_PROT_N = 12;
  localparam int unsigned BIT_OPERATIONAL = 11;
  localparam int unsigned BIT_PAIR_HI = 9;
  localparam int unsigned BIT_PAIR_LO = 8;
  localparam int unsigned BIT_WDOG_ON = 7;
  localparam int unsigned BIT_WINDOW_OFF = 6;
  localparam int unsigned BIT_PRESCALE = 4;
  localparam int unsigned BIT_POST_HI = 3;
  // pin pair codes and prescaler ratios
  localparam logic [1:0] PAIR_ONE = 2'h3;
  localparam logic [1:0] PAIR_TWO = 2'h2;
  localparam logic [1:0] PAIR_THREE = 2'h1;
  localparam logic [7:0] PRESCALE_LONG = 8'h80;
  localparam logic [7:0] PRESCALE_SHORT = 8'h20;
endpackage : fcwl_pkg

// ### verilog/fcwl_load_if.sv
// carrier between the flash fetcher and the loader top
`timescale 1ns/100ps
`default_nettype none
interface fcwl_load_if;
  logic loading;
  logic load_strobe;
  logic [23:0] word_one;
  logic [23:0] word_two;
  modport fetcher (output loading, output load_strobe, output word_one, output word_two);
  modport loader (input loading, input load_strobe, input word_one, input word_two);
endinterface : fcwl_load_if
`default_nettype wire

// ### verilog/fcwl_fetch.sv
// fetches the two configuration words from flash after every reset
`timescale 1ns/100ps
`default_nettype none
module fcwl_fetch (
  input wire logic clk,
  input wire logic resetn,
  output logic flash_rd,
  output logic [23:0] flash_addr,
  input wire logic flash_rvalid,
  input wire logic [23:0] flash_rdata,
  fcwl_load_if.fetcher lif
);
  typedef enum logic [2:0] {ASK_ONE, WAIT_ONE, ASK_TWO, WAIT_TWO, DONE} fcwl_state_e;
  fcwl_state_e state, next_state;
  logic [23:0] addr, next_addr;
  logic [23:0] word_one, next_word_one;
  logic [23:0] word_two, next_word_two;
  logic strobe, next_strobe;

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_word_one = word_one;
    next_word_two = word_two;
    next_strobe = 1'b0;
    case (state)
      ASK_ONE: begin
        next_state = WAIT_ONE;
      end
      WAIT_ONE: begin
        if (flash_rvalid) begin
          next_word_one = flash_rdata;
          next_addr = fcwl_pkg::CW_TWO_ADDR;
          next_state = ASK_TWO;
        end
      end
      ASK_TWO: begin
        next_state = WAIT_TWO;
      end
      WAIT_TWO: begin
        if (flash_rvalid) begin
          next_word_two = flash_rdata;
          next_strobe = 1'b1;
          next_state = DONE;
        end
      end
      DONE: begin
        next_state = DONE;
      end
      default: begin
        next_state = ASK_ONE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ASK_ONE;
      addr <= fcwl_pkg::CW_ONE_ADDR;
      word_one <= 24'hffffff;
      word_two <= 24'hffffff;
      strobe <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      word_one <= next_word_one;
      word_two <= next_word_two;
      strobe <= next_strobe;
    end
  end

  assign flash_rd = (state == ASK_ONE) || (state == ASK_TWO);
  assign flash_addr = addr;
  // loading spans the strobe so the hold drops with the new image
  assign lif.loading = (state != DONE) || strobe;
  assign lif.load_strobe = strobe;
  assign lif.word_one = word_one;
  assign lif.word_two = word_two;

  sequence reset_release_s;
    !resetn ##1 resetn;
  endsequence

  first_fetch_a: assert property (@(posedge clk)
    reset_release_s |-> flash_rd && addr == fcwl_pkg::CW_ONE_ADDR)
    else $error("fetch not restarted");
  // only the two top words are read
  fetch_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    flash_rd |-> (addr == fcwl_pkg::CW_ONE_ADDR || addr == fcwl_pkg::CW_TWO_ADDR))
    else $error("bad fetch address");
  volatile_a: assert property (@(posedge clk) !resetn |=> lif.loading)
    else $error("load not restarted");
endmodule : fcwl_fetch
`default_nettype wire

// ### tb/fcwl_flash_model.sv
// flash array model answering the loader's word fetches
`timescale 1ns/100ps
`default_nettype none
module fcwl_flash_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic flash_rd,
  input wire logic [23:0] flash_addr,
  input wire logic [23:0] word_one,
  input wire logic [23:0] word_two,
  input wire logic [3:0] delay,
  output logic flash_rvalid,
  output logic [23:0] flash_rdata
);
  logic pend = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [23:0] addr = 24'h000000;
  initial flash_rvalid = 1'b0;
  initial flash_rdata = 24'h000000;
  always @(posedge clk) begin
    flash_rvalid <= 1'b0;
    // data toggles outside valid so a stale sample shows up
    flash_rdata <= ~flash_rdata;
    if (!resetn) begin
      pend <= 1'b0;
    end else if (flash_rd) begin
      pend <= 1'b1;
      cnt <= delay;
      addr <= flash_addr;
    end else if (pend && cnt == 4'h0) begin
      pend <= 1'b0;
      flash_rvalid <= 1'b1;
      // top two words hold configuration only
      if (addr == fcwl_pkg::CW_ONE_ADDR) flash_rdata <= word_one;
      else if (addr == fcwl_pkg::CW_TWO_ADDR) flash_rdata <= word_two;
      else flash_rdata <= 24'hffffff;
    end else if (pend) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : fcwl_flash_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the configuration word loader
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic clk = 1'b0, resetn = 1'b0, tbl_rd = 1'b0, tbl_wr = 1'b0;
  logic [23:0] tbl_addr = 24'h0, tbl_wdata = 24'h0, word_one = 24'hffffff;
  logic [23:0] word_two = 24'hffffff, flash_addr, flash_rdata, tbl_rdata, cfg_word_two;
  logic [3:0] delay = 4'h0, post_sel;
  logic flash_rd, flash_rvalid, tbl_ack, hold, bport, cprot, wblk, dbg, wd_on, w_off, w_act;
  logic [1:0] pair;
  logic [2:0] onehot;
  logic [7:0] pre_div;
  logic [15:0] post_div;
  logic [39:0] dec_got;
  int failures = 0, check_count = 0, cyc = 0;
  // upper byte ones, bit15 0, bit10 1, window only with enable
  logic [23:0] words [4] = '{24'hff4cdf, 24'hff3540, 24'hff6e85, 24'hff7f93};
  assign dec_got = {bport, cprot, wblk, dbg, pair, onehot, wd_on, w_off, w_act,
    pre_div, post_sel, post_div};
  fcwl_loader dut_u (.clk(clk), .resetn(resetn), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .flash_rvalid(flash_rvalid), .flash_rdata(flash_rdata),
    .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata),
    .tbl_ack(tbl_ack), .tbl_rdata(tbl_rdata), .sys_reset_hold(hold),
    .cfg_word_two(cfg_word_two), .boundary_port_on(bport), .code_protect_on(cprot),
    .flash_write_block(wblk), .debug_reset_mode(dbg), .emulator_pin_pair_sel(pair),
    .emulator_pair_onehot(onehot), .watchdog_on(wd_on), .window_watchdog_off(w_off),
    .window_watchdog_active(w_act), .watchdog_prescale_div(pre_div),
    .watchdog_postscale_sel(post_sel), .watchdog_postscale_div(post_div));
  fcwl_flash_model flash_u (.clk(clk), .resetn(resetn), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .word_one(word_one), .word_two(word_two), .delay(delay),
    .flash_rvalid(flash_rvalid), .flash_rdata(flash_rdata));
  initial begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic [39:0] dec(input logic [23:0] w);
    logic [1:0] p;
    p = w[9:8];
    dec = {w[14], ~w[13], ~w[12], ~w[11], p, p == 2'h1, p == 2'h2, p == 2'h3, w[7],
      w[6], ~w[6] & w[7], w[4] ? 8'h80 : 8'h20, w[3:0], 16'h0001 << w[3:0]};
  endfunction : dec
  task automatic tbl(input logic wr, input logic [23:0] a, input logic [23:0] d,
    input logic ack, input logic [23:0] rd);
    @(posedge clk);
    #1;
    tbl_rd = ~wr;
    tbl_wr = wr;
    tbl_addr = a;
    tbl_wdata = d;
    @(posedge clk);
    #1;
    tbl_rd = 1'b0;
    tbl_wr = 1'b0;
    `CHK(tbl_ack, ack)
    if (ack && !wr) `CHK(tbl_rdata, rd)
  endtask : tbl
  task automatic boot(input logic [23:0] w1, input logic [23:0] w2, input logic [3:0] dl);
    int n;
    n = 0;
    word_one = w1;
    word_two = w2;
    delay = dl;
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK({hold, flash_rd, flash_addr}, {2'b11, 24'h00abfe})
    `CHK(dec_got, dec(24'hffffff))
    resetn = 1'b1;
    if (dl > 4'h3) tbl(1'b0, 24'hf80000, 24'h0, 1'b0, 24'h0);
    while (hold === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(hold, 1'b0)
    `CHK(n > 2 * dl, 1'b1)
    `CHK(dec_got, dec(w1))
    `CHK(cfg_word_two, w2)
  endtask : boot
  task automatic results();
    $display("mismatches %0d of %0d checks", failures, check_count);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      results();
    end
  end
  initial begin
    logic [15:0] c, m;
    for (int i = 0; i < 4; i++) boot(words[i], {8'hff, ~words[i][15:0]}, 4'(i * 4));
    c = words[3][15:0];
    for (int j = 0; j < 5; j++) begin
      m = fcwl_pkg::LOC_MASK[j];
      tbl(1'b0, 24'hf80000 + 24'(2 * j), 24'h0, 1'b1, {8'hff, (c & m) | ~m});
    end
    tbl(1'b0, 24'h800000, 24'h0, 1'b1, 24'hffffff);
    tbl(1'b0, 24'h7ffffe, 24'h0, 1'b0, 24'h0);
    tbl(1'b1, 24'h00abfe, 24'h0, 1'b0, 24'h0);
    tbl(1'b1, 24'hf80000, 24'hff0000, 1'b1, 24'h0);
    tbl(1'b1, 24'hf80008, 24'hff0009, 1'b1, 24'h0);
    `CHK(dec_got, dec(24'hff0f99))
    boot(words[3], 24'hff1234, 4'h1);
    results();
  end
endmodule : tb
`undef CHK
`default_nettype wire
